// ===== logic/rom_output_matrix.sv
`timescale 1ns/10ps
// Summary of operation
// - binary input state reads 1 when energized, 0 otherwise
// - eight readable start/trip flags for four voltage stages
// - four contact states readable and writable, writes drive contacts
// - one enable gates all four contacts; zero forces them inactive
// - any 0-to-1 change of twelve sources sets a sticky recorded flag
// - on fault first restart; if persistent blink ready and activate supervision
// - during internal fault all contacts except supervision are blocked
// - fault indication has the highest display priority
// - fault indication cannot be cleared while ready is blinking
// - fault gone: stop blinking, supervision normal, message stays
// - readable fault code holds type of last detected fault
// - binary input selects blocking, unlatch, or setting group selection
// - separate setting lets binary input trigger the recorder
// - switch bits 1 and 2 per stage route trips to heavy contacts
// - factory routing sends all trips to both heavy contacts
// - switch bits 3 and 4 per stage route to signalling contacts
// - factory routing sends all starts to both signalling contacts
// - supervision contact energized normally, drops off on fault
// - function switch bit 1 selects single-phase operation
// - writing 1 to clear command clears records and unlatches contacts
module rom_output_matrix #(
  parameter int RESTART_LEN = rom_pkg::RESTART_CYCLES,
  parameter int BLINK_LEN   = 4096
) (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       binaryInput,
  input  wire logic [7:0] stageFlags,
  input  wire logic       faultDetect,
  input  wire logic [7:0] faultType,
  input  wire logic       displayClear,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [5:0] regAddr,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  output logic            heavyContactA,
  output logic            heavyContactB,
  output logic            signalContactA,
  output logic            signalContactB,
  output logic            selfSupervisionContact,
  output logic            readyLed,
  output logic            faultMessage,
  output logic            restartReq,
  output logic            externalBlock,
  output logic            settingGroup2,
  output logic            recorderTrigger,
  output logic            singlePhase
);

  // =====================================================================
  // register map, one index per value on the parameter port
  //   0x00        binary input state
  //   0x01-0x08   stage flags, start then trip per stage
  //   0x09-0x0c   contact states, heavy a/b then signal a/b
  //   0x15-0x20   recorded flags, stage flags then contacts
  //   0x29        contact enable
  //   0x2a-0x31   route switches, bit0 heavy a .. bit3 signal b
  //   0x32        binary input function
  //   0x33        function switches
  //   0x34        recorder trigger select
  //   0x35        clear recorded flags and unlatch (bit0)
  //   0x36        fault code
  //   0x37        nominal voltage setting, not range checked
  //   writes to read-only indices are dropped; unmapped reads give zero

  // =====================================================================
  // index decode, one hit line per stage, contact and recorded flag
  logic [rom_pkg::NUM_STAGE_SIG-1:0] routeWrHit;
  logic [rom_pkg::NUM_STAGE_SIG-1:0] routeRdHit;
  logic [rom_pkg::NUM_STAGE_SIG-1:0] flagRdHit;
  logic [rom_pkg::NUM_CONTACTS-1:0]  contactWrHit;
  logic [rom_pkg::NUM_CONTACTS-1:0]  contactRdHit;
  logic [rom_pkg::NUM_REC-1:0]       recRdHit;

  for (genvar g = 0; g < rom_pkg::NUM_STAGE_SIG; g++) begin : gStageDecode
    assign routeWrHit[g] = regWrite && regAddr == 6'(rom_pkg::REG_ROUTE_BASE + 6'(g));
    assign routeRdHit[g] = regAddr == 6'(rom_pkg::REG_ROUTE_BASE + 6'(g));
    assign flagRdHit[g]  = regAddr == 6'(rom_pkg::REG_STAGE_FLAG_BASE + 6'(g));
  end

  for (genvar g = 0; g < rom_pkg::NUM_CONTACTS; g++) begin : gContactDecode
    assign contactWrHit[g] = regWrite && regAddr == 6'(rom_pkg::REG_CONTACT_BASE + 6'(g));
    assign contactRdHit[g] = regAddr == 6'(rom_pkg::REG_CONTACT_BASE + 6'(g));
  end

  for (genvar g = 0; g < rom_pkg::NUM_REC; g++) begin : gRecDecode
    assign recRdHit[g] = regAddr == 6'(rom_pkg::REG_REC_BASE + 6'(g));
  end

  // =====================================================================
  // settings
  logic [3:0] routeSwitches_r [rom_pkg::NUM_STAGE_SIG];
  logic [3:0] routeSwitches_nxt [rom_pkg::NUM_STAGE_SIG];
  logic [1:0] inputFunctionSelect_r, inputFunctionSelect_nxt;
  logic [7:0] functionSwitchesTwo_r, functionSwitchesTwo_nxt;
  logic       recorderTriggerSelect_r, recorderTriggerSelect_nxt;
  logic [7:0] nominalVoltageSelect_r, nominalVoltageSelect_nxt;
  logic       contactEnable_r, contactEnable_nxt;

  // bit0 must be 1; writing 0 to the clear index does nothing
  logic       clearCmd;
  assign clearCmd = regWrite && regAddr == rom_pkg::REG_CLEAR_UNLATCH && regWdata[0];

  always_comb begin
    for (int i = 0; i < rom_pkg::NUM_STAGE_SIG; i++) begin
      routeSwitches_nxt[i] = routeSwitches_r[i];
      if (routeWrHit[i]) begin
        routeSwitches_nxt[i] = regWdata[3:0];
      end
    end
    inputFunctionSelect_nxt   = inputFunctionSelect_r;
    functionSwitchesTwo_nxt   = functionSwitchesTwo_r;
    recorderTriggerSelect_nxt = recorderTriggerSelect_r;
    nominalVoltageSelect_nxt  = nominalVoltageSelect_r;
    contactEnable_nxt         = contactEnable_r;
    if (regWrite) begin
      unique case (regAddr)
        rom_pkg::REG_INPUT_FUNC_SELECT: inputFunctionSelect_nxt   = regWdata[1:0];
        rom_pkg::REG_FUNC_SWITCHES_TWO: functionSwitchesTwo_nxt   = regWdata;
        rom_pkg::REG_REC_TRIG_SELECT:   recorderTriggerSelect_nxt = regWdata[0];
        rom_pkg::REG_NOMINAL_VOLT_SEL:  nominalVoltageSelect_nxt  = regWdata;
        rom_pkg::REG_CONTACT_ENABLE:    contactEnable_nxt         = regWdata[0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < rom_pkg::NUM_STAGE_SIG; i++) begin
        // even stage indices are starts, odd are trips
        routeSwitches_r[i] <= i[0] ? rom_pkg::ROUTE_DEFAULT_TRIP : rom_pkg::ROUTE_DEFAULT_START;
      end
      inputFunctionSelect_r   <= rom_pkg::BIN_FUNC_NONE;
      functionSwitchesTwo_r   <= 8'h00;
      recorderTriggerSelect_r <= 1'b0;
      nominalVoltageSelect_r  <= rom_pkg::NOMINAL_VOLT_RESET;
      contactEnable_r         <= 1'b1;
    end else begin
      routeSwitches_r         <= routeSwitches_nxt;
      inputFunctionSelect_r   <= inputFunctionSelect_nxt;
      functionSwitchesTwo_r   <= functionSwitchesTwo_nxt;
      recorderTriggerSelect_r <= recorderTriggerSelect_nxt;
      nominalVoltageSelect_r  <= nominalVoltageSelect_nxt;
      contactEnable_r         <= contactEnable_nxt;
    end
  end

  // =====================================================================
  // binary input functions
  // block and unlatch act on the level, not an edge of the input
  logic binBlock, binUnlatch;
  assign binBlock   = binaryInput && inputFunctionSelect_r == rom_pkg::BIN_FUNC_BLOCK;
  assign binUnlatch = binaryInput && inputFunctionSelect_r == rom_pkg::BIN_FUNC_UNLATCH;

  // =====================================================================
  // self-supervision
  rom_pkg::rom_sup_e supState_r, supState_nxt;
  logic [15:0] supCount_r, supCount_nxt;
  logic        blink_r, blink_nxt;
  logic        faultMsg_r, faultMsg_nxt;
  logic [7:0]  faultCode_r, faultCode_nxt;

  always_comb begin
    supState_nxt  = supState_r;
    supCount_nxt  = supCount_r;
    blink_nxt     = blink_r;
    faultMsg_nxt  = faultMsg_r;
    faultCode_nxt = faultCode_r;
    unique case (supState_r)
      rom_pkg::ROM_SUP_NORMAL: begin
        blink_nxt = 1'b0;
        if (faultDetect) begin
          supState_nxt  = rom_pkg::ROM_SUP_RESTART;
          supCount_nxt  = 16'h0000;
          faultCode_nxt = faultType;
        end
      end
      rom_pkg::ROM_SUP_RESTART: begin
        // a fault that clears inside the restart window never reaches
        // the contacts or the message; supervision stays energized here
        supCount_nxt = supCount_r + 16'h0001;
        if (!faultDetect) begin
          supState_nxt = rom_pkg::ROM_SUP_NORMAL;
        end else if (supCount_r == 16'(RESTART_LEN - 1)) begin
          supState_nxt = rom_pkg::ROM_SUP_FAULT;
          supCount_nxt = 16'h0000;
          faultMsg_nxt = 1'b1;
        end
      end
      rom_pkg::ROM_SUP_FAULT: begin
        // counter wraps at BLINK_LEN so the led toggles with a steady period
        supCount_nxt = (supCount_r == 16'(BLINK_LEN - 1)) ? 16'h0000 : supCount_r + 16'h0001;
        if (supCount_r == 16'(BLINK_LEN - 1)) begin
          blink_nxt = ~blink_r;
        end
        if (faultDetect) begin
          faultCode_nxt = faultType;
        end else begin
          supState_nxt = rom_pkg::ROM_SUP_NORMAL;
          blink_nxt    = 1'b0;
        end
      end
    endcase
    // message stays after the fault leaves; only clearable when not blinking
    if (displayClear && supState_r != rom_pkg::ROM_SUP_FAULT) begin
      faultMsg_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      supState_r  <= rom_pkg::ROM_SUP_NORMAL;
      supCount_r  <= 16'h0000;
      blink_r     <= 1'b0;
      faultMsg_r  <= 1'b0;
      faultCode_r <= 8'h00;
    end else begin
      supState_r  <= supState_nxt;
      supCount_r  <= supCount_nxt;
      blink_r     <= blink_nxt;
      faultMsg_r  <= faultMsg_nxt;
      faultCode_r <= faultCode_nxt;
    end
  end

  logic permFault;
  assign permFault = supState_r == rom_pkg::ROM_SUP_FAULT;

  // =====================================================================
  // contact matrix with latching
  // every stage ORs into each contact that its switch bits allow
  logic [3:0] routed;
  always_comb begin
    routed = 4'h0;
    for (int i = 0; i < rom_pkg::NUM_STAGE_SIG; i++) begin
      routed = routed | ({4{stageFlags[i]}} & routeSwitches_r[i]);
    end
  end

  logic [3:0] contactState_r, contactState_nxt;
  always_comb begin
    contactState_nxt = contactState_r | routed;
    if (clearCmd || binUnlatch) begin
      contactState_nxt = routed;
    end
    for (int c = 0; c < rom_pkg::NUM_CONTACTS; c++) begin
      if (contactWrHit[c]) begin
        contactState_nxt[c] = regWdata[0];
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      contactState_r <= 4'h0;
    end else begin
      contactState_r <= contactState_nxt;
    end
  end

  // blocking and enable have priority over routed state
  // drives are registered, so a block or fault takes one cycle to the pins;
  // the enable only gates drives, latched states survive a disable
  logic [3:0] driven_r, driven_nxt;
  always_comb begin
    driven_nxt = contactState_r & {4{contactEnable_r}};
    if (permFault || binBlock) begin
      driven_nxt = 4'h0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      driven_r <= 4'h0;
    end else begin
      driven_r <= driven_nxt;
    end
  end

  // =====================================================================
  // recorded flags
  // set beats clear in one cycle, so no 0-to-1 edge is lost;
  // contact states feed the detector, so a host write is recorded too
  logic [11:0] recSource, recPrev_r, recorded_r, recorded_nxt;
  assign recSource = {contactState_r, stageFlags};

  always_comb begin
    recorded_nxt = recorded_r;
    if (clearCmd) begin
      recorded_nxt = 12'h000;
    end
    recorded_nxt = recorded_nxt | (recSource & ~recPrev_r);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      recPrev_r  <= 12'h000;
      recorded_r <= 12'h000;
    end else begin
      recPrev_r  <= recSource;
      recorded_r <= recorded_nxt;
    end
  end

  // =====================================================================
  // register read
  // regRdata only moves on a read strobe and holds between reads
  logic [7:0] rdata_nxt;
  always_comb begin
    rdata_nxt = 8'h00;
    if (regAddr == rom_pkg::REG_BINARY_INPUT_STATE) begin
      rdata_nxt = {7'h00, binaryInput};
    end
    for (int i = 0; i < rom_pkg::NUM_STAGE_SIG; i++) begin
      if (flagRdHit[i]) rdata_nxt = {7'h00, stageFlags[i]};
      if (routeRdHit[i]) rdata_nxt = {4'h0, routeSwitches_r[i]};
    end
    for (int c = 0; c < rom_pkg::NUM_CONTACTS; c++) begin
      if (contactRdHit[c]) rdata_nxt = {7'h00, contactState_r[c]};
    end
    for (int r = 0; r < rom_pkg::NUM_REC; r++) begin
      if (recRdHit[r]) rdata_nxt = {7'h00, recorded_r[r]};
    end
    // fixed indices never overlap the per-entry ranges above
    unique case (regAddr)
      rom_pkg::REG_CONTACT_ENABLE:    rdata_nxt = {7'h00, contactEnable_r};
      rom_pkg::REG_INPUT_FUNC_SELECT: rdata_nxt = {6'h00, inputFunctionSelect_r};
      rom_pkg::REG_FUNC_SWITCHES_TWO: rdata_nxt = functionSwitchesTwo_r;
      rom_pkg::REG_REC_TRIG_SELECT:   rdata_nxt = {7'h00, recorderTriggerSelect_r};
      rom_pkg::REG_NOMINAL_VOLT_SEL:  rdata_nxt = nominalVoltageSelect_r;
      rom_pkg::REG_FAULT_CODE:        rdata_nxt = faultCode_r;
      default: ;
    endcase
    if (!regRead) begin
      rdata_nxt = regRdata;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      regRdata <= 8'h00;
    end else begin
      regRdata <= rdata_nxt;
    end
  end

  // =====================================================================
  // outputs
  // supervision is high while healthy, so a dead supply reads as a fault
  assign heavyContactA          = driven_r[rom_pkg::ROUTE_HEAVY_A];
  assign heavyContactB          = driven_r[rom_pkg::ROUTE_HEAVY_B];
  assign signalContactA         = driven_r[rom_pkg::ROUTE_SIGNAL_A];
  assign signalContactB         = driven_r[rom_pkg::ROUTE_SIGNAL_B];
  assign selfSupervisionContact = !permFault;
  assign readyLed               = !blink_r;
  assign faultMessage           = faultMsg_r;
  assign restartReq             = supState_r == rom_pkg::ROM_SUP_RESTART;
  assign externalBlock          = binBlock;
  assign settingGroup2          = binaryInput && inputFunctionSelect_r == rom_pkg::BIN_FUNC_GROUP;
  assign recorderTrigger        = binaryInput && recorderTriggerSelect_r;
  assign singlePhase            = functionSwitchesTwo_r[rom_pkg::FUNC_SINGLE_PH];

endmodule : rom_output_matrix

// ===== logic/rom_pkg.sv
package rom_pkg;
  // =====================================================================
  // register indices on the parameter port (no offsets are printed)
  localparam logic [5:0] REG_BINARY_INPUT_STATE = 6'h00;
  localparam logic [5:0] REG_STAGE_FLAG_BASE    = 6'h01;
  localparam logic [5:0] REG_CONTACT_BASE       = 6'h09;
  localparam logic [5:0] REG_REC_BASE           = 6'h15;
  localparam logic [5:0] REG_CONTACT_ENABLE     = 6'h29;
  localparam logic [5:0] REG_ROUTE_BASE         = 6'h2a;
  localparam logic [5:0] REG_INPUT_FUNC_SELECT  = 6'h32;
  localparam logic [5:0] REG_FUNC_SWITCHES_TWO  = 6'h33;
  localparam logic [5:0] REG_REC_TRIG_SELECT    = 6'h34;
  localparam logic [5:0] REG_CLEAR_UNLATCH      = 6'h35;
  localparam logic [5:0] REG_FAULT_CODE         = 6'h36;
  localparam logic [5:0] REG_NOMINAL_VOLT_SEL   = 6'h37;

  // =====================================================================
  // counts and field positions
  localparam int NUM_STAGE_SIG   = 8;
  localparam int NUM_CONTACTS    = 4;
  localparam int NUM_REC         = 12;
  localparam int ROUTE_HEAVY_A   = 0;
  localparam int ROUTE_HEAVY_B   = 1;
  localparam int ROUTE_SIGNAL_A  = 2;
  localparam int ROUTE_SIGNAL_B  = 3;
  localparam int FUNC_SINGLE_PH  = 0;

  // factory routing: trips to heavy contacts, starts to signalling contacts
  localparam logic [3:0] ROUTE_DEFAULT_START = 4'hc;
  localparam logic [3:0] ROUTE_DEFAULT_TRIP  = 4'h3;

  localparam logic [7:0] NOMINAL_VOLT_RESET = 8'h64;

  // =====================================================================
  // binary input functions
  localparam logic [1:0] BIN_FUNC_NONE    = 2'h0;
  localparam logic [1:0] BIN_FUNC_BLOCK   = 2'h1;
  localparam logic [1:0] BIN_FUNC_UNLATCH = 2'h2;
  localparam logic [1:0] BIN_FUNC_GROUP   = 2'h3;

  // =====================================================================
  // restart window in clock cycles before a fault counts as permanent
  localparam int RESTART_CYCLES = 16;

  typedef enum {
    ROM_SUP_NORMAL,
    ROM_SUP_RESTART,
    ROM_SUP_FAULT
  } rom_sup_e;
endpackage : rom_pkg

// ===== verif/rom_output_matrix_monitor.sv
`timescale 1ns/10ps
module rom_output_matrix_monitor #(
  parameter int BLINK_LEN = 4096
) (
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic       binaryInput,
  input wire logic       displayClear,
  input wire logic       regRead,
  input wire logic [5:0] regAddr,
  input wire logic [7:0] regRdata,
  input wire logic       heavyContactA,
  input wire logic       heavyContactB,
  input wire logic       signalContactA,
  input wire logic       signalContactB,
  input wire logic       selfSupervisionContact,
  input wire logic       readyLed,
  input wire logic       faultMessage,
  input wire logic       restartReq
);
  // ==========
  // blink watch
  // fault cycles since the ready led last moved
  int idleCnt;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      idleCnt <= 0;
    end else begin
      idleCnt <= (selfSupervisionContact || $changed(readyLed)) ? 0 : idleCnt + 1;
    end
  end
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // ==========
  // properties
  sup_block_a: assert property ((!selfSupervisionContact) [*2] |->
    !(heavyContactA || heavyContactB || signalContactA || signalContactB)) else $error("contact active in fault");
  restart_first_a: assert property ($fell(selfSupervisionContact) |-> $past(restartReq))
    else $error("fault without restart");
  restart_hold_a: assert property ($rose(restartReq) |-> selfSupervisionContact [*8])
    else $error("supervision dropped during restart");
  blink_period_a: assert property (idleCnt <= BLINK_LEN + 1)
    else $error("ready led not blinking in fault");
  led_steady_a: assert property (selfSupervisionContact [*3] |-> $stable(readyLed))
    else $error("ready led blinks without fault");
  msg_in_fault_a: assert property ((!selfSupervisionContact) [*2] |-> faultMessage)
    else $error("fault message missing");
  no_clear_a: assert property (!selfSupervisionContact && displayClear |=> faultMessage)
    else $error("fault message cleared while blinking");
  msg_keep_a: assert property ($rose(selfSupervisionContact) |-> faultMessage)
    else $error("fault message lost on recovery");
  read_bin_a: assert property (regRead && regAddr == 6'h00 && $stable(binaryInput) |=>
    regRdata == {7'h00, $past(binaryInput)}) else $error("binary input read wrong");
  cover property ($fell(selfSupervisionContact));
  cover property ($rose(selfSupervisionContact));
  cover property (heavyContactA && heavyContactB);
endmodule : rom_output_matrix_monitor

// ===== verif/rom_host_model.sv
`timescale 1ns/10ps
module rom_host_model (
  input  wire logic       clock,
  input  wire logic [7:0] regRdata,
  output logic            regWrite,
  output logic            regRead,
  output logic      [5:0] regAddr,
  output logic      [7:0] regWdata
);
  // ==========
  // parameter host
  // only the four listed ratings are ever chosen
  localparam logic [7:0] VOLTS [4] = '{8'h64, 8'h6e, 8'h73, 8'h78};
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 6'h00;
    regWdata = 8'h00;
  end
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    d = regRdata;
  endtask : rd
  task automatic set_nominal(input int k);
    wr(rom_pkg::REG_NOMINAL_VOLT_SEL, VOLTS[k]);
  endtask : set_nominal
endmodule : rom_host_model

// ===== verif/tb_rom_output_matrix.sv
`timescale 1ns/10ps
module tb_rom_output_matrix;
  localparam int RLEN = 16;
  // short blink keeps the fault run brief
  localparam int BLEN = 4;
  logic       clock, resetn, binaryInput, faultDetect, displayClear;
  logic [7:0] stageFlags, faultType, regWdata, regRdata;
  logic       regWrite, regRead;
  logic [5:0] regAddr;
  logic       heavyContactA, heavyContactB, signalContactA, signalContactB;
  logic       selfSupervisionContact, readyLed, faultMessage, restartReq;
  logic       externalBlock, settingGroup2, recorderTrigger, singlePhase;
  logic [3:0] outs;
  int         num_errors, num_checks, cycles;
  assign outs = {signalContactB, signalContactA, heavyContactB, heavyContactA};
  rom_output_matrix #(.RESTART_LEN(RLEN), .BLINK_LEN(BLEN)) dut (
    .clock, .resetn, .binaryInput, .stageFlags, .faultDetect, .faultType, .displayClear, .regWrite,
    .regRead, .regAddr, .regWdata, .regRdata, .heavyContactA, .heavyContactB, .signalContactA,
    .signalContactB, .selfSupervisionContact, .readyLed, .faultMessage, .restartReq, .externalBlock,
    .settingGroup2, .recorderTrigger, .singlePhase);
  rom_host_model host (.clock, .regRdata, .regWrite, .regRead, .regAddr, .regWdata);
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  // ==========
  // helpers
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic rdchk(input string nm, input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk(nm, d, exp);
  endtask : rdchk
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic pulse_clear();
    @(posedge clock);
    displayClear <= 1'b1;
    @(posedge clock);
    displayClear <= 1'b0;
    tick(2);
  endtask : pulse_clear
  // ==========
  // scenarios
  task automatic t_reset();
    chk("outs", {4'h0, outs}, 8'h00);
    chk("sup", {7'h0, selfSupervisionContact}, 8'h01);
    rdchk("enable", rom_pkg::REG_CONTACT_ENABLE, 8'h01);
    for (int i = 0; i < 8; i++)
      rdchk("route", rom_pkg::REG_ROUTE_BASE + 6'(i), i % 2 ? 8'h03 : 8'h0c);
  endtask : t_reset
  task automatic t_flags();
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      stageFlags <= 8'h01 << i;
      rdchk("flag", rom_pkg::REG_STAGE_FLAG_BASE + 6'(i), 8'h01);
      chk("routed", {4'h0, outs}, i % 2 ? 8'h03 : 8'h0c);
      rdchk("rec", rom_pkg::REG_REC_BASE + 6'(i), 8'h01);
      @(posedge clock);
      stageFlags <= 8'h00;
      tick(2);
      chk("latched", {4'h0, outs}, i % 2 ? 8'h03 : 8'h0c);
      host.wr(rom_pkg::REG_CLEAR_UNLATCH, 8'h01);
      rdchk("recclr", rom_pkg::REG_REC_BASE + 6'(i), 8'h00);
      chk("unlatched", {4'h0, outs}, 8'h00);
    end
  endtask : t_flags
  task automatic t_route();
    // over1 trip steered to the first signalling contact only
    host.wr(rom_pkg::REG_ROUTE_BASE + 6'h1, 8'h04);
    @(posedge clock);
    stageFlags <= 8'h02;
    tick(3);
    chk("reroute", {4'h0, outs}, 8'h04);
    @(posedge clock);
    stageFlags <= 8'h00;
    host.wr(rom_pkg::REG_ROUTE_BASE + 6'h1, 8'h03);
    host.wr(rom_pkg::REG_CLEAR_UNLATCH, 8'h01);
  endtask : t_route
  task automatic t_state();
    host.wr(rom_pkg::REG_CONTACT_BASE, 8'h01);
    tick(2);
    chk("heavyA", {4'h0, outs}, 8'h01);
    rdchk("stateA", rom_pkg::REG_CONTACT_BASE, 8'h01);
    rdchk("recA", rom_pkg::REG_REC_BASE + 6'h8, 8'h01);
    host.wr(rom_pkg::REG_CONTACT_ENABLE, 8'h00);
    tick(2);
    chk("gated", {4'h0, outs}, 8'h00);
    host.wr(rom_pkg::REG_CONTACT_ENABLE, 8'h01);
    tick(2);
    chk("ungated", {4'h0, outs}, 8'h01);
  endtask : t_state
  task automatic t_fault();
    logic led0;
    @(posedge clock);
    faultDetect <= 1'b1;
    faultType <= 8'h33;
    tick(3);
    chk("restart", {7'h0, restartReq}, 8'h01);
    @(posedge clock);
    faultDetect <= 1'b0;
    tick(RLEN + 4);
    chk("transient", {7'h0, selfSupervisionContact}, 8'h01);
    @(posedge clock);
    faultDetect <= 1'b1;
    faultType <= 8'h5a;
    tick(RLEN + 5);
    chk("supdrop", {7'h0, selfSupervisionContact}, 8'h00);
    chk("blocked", {4'h0, outs}, 8'h00);
    chk("msg", {7'h0, faultMessage}, 8'h01);
    rdchk("code", rom_pkg::REG_FAULT_CODE, 8'h5a);
    led0 = readyLed;
    tick(BLEN);
    chk("blink", {7'h0, readyLed}, {7'h0, ~led0});
    pulse_clear();
    chk("noclear", {7'h0, faultMessage}, 8'h01);
    @(posedge clock);
    faultDetect <= 1'b0;
    tick(3);
    chk("suprise", {7'h0, selfSupervisionContact}, 8'h01);
    chk("msgkeep", {7'h0, faultMessage}, 8'h01);
    chk("restored", {4'h0, outs}, 8'h01);
    pulse_clear();
    chk("cleared", {7'h0, faultMessage}, 8'h00);
  endtask : t_fault
  task automatic t_binary();
    @(posedge clock);
    binaryInput <= 1'b1;
    rdchk("binon", rom_pkg::REG_BINARY_INPUT_STATE, 8'h01);
    for (int m = 0; m < 4; m++) begin
      host.wr(rom_pkg::REG_INPUT_FUNC_SELECT, 8'(m));
      tick(2);
      chk("block", {7'h0, externalBlock}, 8'(m == 1));
      chk("group", {7'h0, settingGroup2}, 8'(m == 3));
      chk("drive", {4'h0, outs}, m == 0 ? 8'h01 : 8'h00);
      rdchk("state", rom_pkg::REG_CONTACT_BASE, m < 2 ? 8'h01 : 8'h00);
    end
    host.wr(rom_pkg::REG_INPUT_FUNC_SELECT, 8'h00);
    binaryInput <= 1'b0;
    rdchk("binoff", rom_pkg::REG_BINARY_INPUT_STATE, 8'h00);
    host.wr(rom_pkg::REG_REC_TRIG_SELECT, 8'h01);
    binaryInput <= 1'b1;
    tick(1);
    chk("trig", {7'h0, recorderTrigger}, 8'h01);
    host.wr(rom_pkg::REG_FUNC_SWITCHES_TWO, 8'h01);
    tick(1);
    chk("phase", {7'h0, singlePhase}, 8'h01);
    for (int k = 0; k < 4; k++)
      host.set_nominal(k);
  endtask : t_binary
  initial begin
    resetn = 1'b0;
    binaryInput = 1'b0;
    faultDetect = 1'b0;
    displayClear = 1'b0;
    stageFlags = 8'h00;
    faultType = 8'h00;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    tick(1);
    t_reset();
    t_flags();
    t_route();
    t_state();
    t_fault();
    t_binary();
    tally_and_finish();
  end
endmodule : tb_rom_output_matrix
bind rom_output_matrix rom_output_matrix_monitor #(.BLINK_LEN(BLINK_LEN)) mon (
  .clock, .resetn, .binaryInput, .displayClear, .regRead, .regAddr, .regRdata, .heavyContactA,
  .heavyContactB, .signalContactA, .signalContactB, .selfSupervisionContact, .readyLed, .faultMessage,
  .restartReq);
